// ==== rtl/crba_core.sv ====
// coefficient memory with block command addressing and a downward word walk
// Operation
// - the memory holds forty words in five blocks of eight, each word named by a 6-bit address.
// - a command names only a 3-bit block and the device then touches all eight words of it in that one command.
// - the low word index counts down from 111 to 000 so the highest word goes first.
// - the block number forms the upper three address bits and the device supplies the lower three.
// - block 100 carries the receive gain and receive frequency-response words together.
// - block 000 is impedance matching, 001 first filter, 010 second filter, 011 transmit response then gain, 100 receive response then gain.
`timescale 1ns/10ps
module crba_core (
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  input  wire logic                        i_cmd_valid,
  input  wire crba_pkg::crba_cmd_t         i_cmd,
  output logic                             o_cmd_ready,
  output crba_pkg::crba_word_t             o_word,
  output logic                             o_done,
  output logic                             o_bad_block
);
  import crba_pkg::*;

  // one register per word, each with its own write strobe
  logic [DATA_W-1:0] mem_q [WORD_COUNT];
  crba_state_t       state_q;
  crba_state_t       state_d;
  logic [2:0]        block_q;
  logic [2:0]        idx_q;
  logic [2:0]        idx_d;
  logic              write_q;
  logic [DATA_W-1:0] wdata_q;
  logic [5:0]        addr_d;
  crba_set_t         set_d;
  logic              bad_d;
  logic              take;
  logic              walking;
  logic              last_step;
  logic [DATA_W-1:0] rd_data;
  logic              out_valid_q;
  logic              out_write_q;
  logic [5:0]        out_addr_q;
  crba_set_t         out_set_q;
  logic [DATA_W-1:0] out_data_q;
  logic              done_q;
  logic              bad_q;

  assign o_cmd_ready = (state_q == CRBA_IDLE);
  assign bad_d       = (i_cmd.block > BLK_LAST_VALID);
  // a refused block never leaves idle, so it cannot alias onto real words
  assign take        = o_cmd_ready && i_cmd_valid && !bad_d;
  assign walking     = (state_q == CRBA_WALK);
  assign last_step   = walking && (idx_q == IDX_LAST);
  assign addr_d      = {block_q, idx_q};
  assign rd_data     = mem_q[addr_d];

  always_comb begin
    set_d = CRBA_NONE;
    case (block_q)
      BLK_IMPEDANCE: set_d = CRBA_IMPEDANCE;
      BLK_FILTER1:   set_d = CRBA_FIRST_FILTER;
      BLK_FILTER2:   set_d = CRBA_SECOND_FILTER;
      BLK_TRANSMIT:  set_d = (idx_q >= IDX_GAIN_MIN) ? CRBA_TX_GAIN : CRBA_TX_FREQ_RESP;
      // one block reaches both receive groups, so a single command rewrites both
      BLK_RECEIVE:   set_d = (idx_q >= IDX_GAIN_MIN) ? CRBA_RX_GAIN : CRBA_RX_FREQ_RESP;
      default:       set_d = CRBA_NONE;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      CRBA_IDLE: begin
        if (take) begin
          state_d = CRBA_WALK;
        end
      end
      CRBA_WALK: begin
        if (idx_q == IDX_LAST) begin
          state_d = CRBA_DONE;
        end
      end
      // one extra busy cycle keeps accepted commands ten cycles apart
      CRBA_DONE: state_d = CRBA_IDLE;
      default:   state_d = CRBA_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= CRBA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    idx_d = idx_q;
    if (take) begin
      idx_d = IDX_FIRST;
    end else if (walking && (idx_q != IDX_LAST)) begin
      idx_d = idx_q - 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      idx_q <= IDX_FIRST;
    end else begin
      idx_q <= idx_d;
    end
  end

  // command fields are latched once and held for the whole walk
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      block_q <= 3'h0;
    end else if (take) begin
      block_q <= i_cmd.block;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      write_q <= 1'b0;
    end else if (take) begin
      write_q <= i_cmd.write;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdata_q <= RST_DATA;
    end else if (take) begin
      wdata_q <= i_cmd.wdata;
    end
  end

  // one shared write word per command; a wider front end would feed a word per step
  for (genvar gi = 0; gi < WORD_COUNT; gi++) begin : g_word
    logic we;
    assign we = walking && write_q && (addr_d == 6'(gi));
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        mem_q[gi] <= RST_DATA;
      end else if (we) begin
        mem_q[gi] <= wdata_q;
      end
    end
  end

  // outputs are registered, so each word shows one cycle after its walk step
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= walking;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_write_q <= 1'b0;
    end else begin
      out_write_q <= write_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_addr_q <= RST_ADDR;
    end else begin
      out_addr_q <= addr_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_set_q <= CRBA_NONE;
    end else begin
      out_set_q <= set_d;
    end
  end

  // a write echoes the written word, a read the word as it was stored
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_data_q <= RST_DATA;
    end else begin
      out_data_q <= write_q ? wdata_q : rd_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= last_step;
    end
  end

  // a refused offer is flagged once and the block stays ready
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bad_q <= 1'b0;
    end else begin
      bad_q <= o_cmd_ready && i_cmd_valid && bad_d;
    end
  end

  assign o_word = '{
    valid: out_valid_q,
    write: out_write_q,
    addr:  out_addr_q,
    set:   out_set_q,
    data:  out_data_q
  };
  assign o_done      = done_q;
  assign o_bad_block = bad_q;

endmodule

// ==== rtl/crba_pkg.sv ====
// package: constants and carriers for the coefficient memory block addressing logic
package crba_pkg;

  localparam int unsigned WORD_COUNT  = 40;
  localparam int unsigned BLOCK_WORDS = 8;
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned BLOCK_W     = 3;
  localparam int unsigned DATA_W      = 16;

  localparam logic [2:0] BLK_IMPEDANCE  = 3'h0;
  localparam logic [2:0] BLK_FILTER1    = 3'h1;
  localparam logic [2:0] BLK_FILTER2    = 3'h2;
  localparam logic [2:0] BLK_TRANSMIT   = 3'h3;
  localparam logic [2:0] BLK_RECEIVE    = 3'h4;
  localparam logic [2:0] BLK_LAST_VALID = 3'h4;
  localparam logic [2:0] IDX_FIRST      = 3'h7;
  localparam logic [2:0] IDX_LAST       = 3'h0;
  localparam logic [2:0] IDX_GAIN_MIN   = 3'h4;

  localparam logic [5:0]        RST_ADDR = 6'h00;
  localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;

  typedef enum logic [3:0] {
    CRBA_NONE           = 4'h0,
    CRBA_IMPEDANCE      = 4'h1,
    CRBA_FIRST_FILTER   = 4'h2,
    CRBA_SECOND_FILTER  = 4'h3,
    CRBA_TX_FREQ_RESP   = 4'h4,
    CRBA_TX_GAIN        = 4'h5,
    CRBA_RX_FREQ_RESP   = 4'h6,
    CRBA_RX_GAIN        = 4'h7
  } crba_set_t;

  typedef enum logic [2:0] {
    CRBA_IDLE  = 3'b001,
    CRBA_WALK  = 3'b010,
    CRBA_DONE  = 3'b100
  } crba_state_t;

  typedef struct packed {
    logic              write;
    logic [2:0]        block;
    logic [DATA_W-1:0] wdata;
  } crba_cmd_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [5:0]        addr;
    crba_set_t         set;
    logic [DATA_W-1:0] data;
  } crba_word_t;

endpackage

// ==== bench/crba_host.sv ====
// host model issuing block commands
`timescale 1ns/10ps
module crba_host import crba_pkg::*; (
  input  wire logic i_clk,
  input  wire logic i_ready,
  output logic      o_valid,
  output crba_cmd_t o_cmd
);
  initial o_valid = 1'b0;
  initial o_cmd = '0;
  // held until the core is ready, taken or refused; released fields are scrambled so stale values never pass
  task automatic send(input logic [2:0] b, input logic w, input logic [15:0] d);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_cmd = {w, b, d};
    do @(posedge i_clk); while (!i_ready);
    @(negedge i_clk);
    o_valid = 1'b0;
    o_cmd = ~o_cmd;
  endtask
endmodule

// ==== bench/crba_checker.sv ====
// checker: block walk assertions at the core ports
`timescale 1ns/10ps
module crba_checker import crba_pkg::*; (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_cmd_valid,
  input wire crba_cmd_t  i_cmd,
  input wire logic       o_cmd_ready,
  input wire crba_word_t o_word,
  input wire logic       o_done,
  input wire logic       o_bad_block
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_take; i_cmd_valid && o_cmd_ready && i_cmd.block <= 3'h4; endsequence
  sequence s_walk; o_word.valid [*8] ##1 !o_word.valid; endsequence
  property p_walk; s_take |-> ##2 s_walk; endproperty
  a_walk: assert property (p_walk) else $error("walk");
  property p_busy; s_take |=> !o_cmd_ready [*8] ##1 !o_cmd_ready ##1 o_cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_first; s_take |-> ##2 o_word.addr == {$past(i_cmd.block, 2), 3'h7}; endproperty
  a_first: assert property (p_first) else $error("first");
  property p_step; o_word.valid && o_word.addr[2:0] != 3'h0 |=> o_word.addr == $past(o_word.addr) - 6'h01; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_range; o_word.valid |-> o_word.addr[5:3] <= 3'h4; endproperty
  a_range: assert property (p_range) else $error("range");
  property p_set; o_word.valid |-> o_word.set == ((o_word.addr[5:3] < 3'h3) ?
    {1'b0, o_word.addr[5:3]} + 4'h1 : {o_word.addr[5:3], o_word.addr[2]} - 4'h2); endproperty
  a_set: assert property (p_set) else $error("set");
  property p_done; o_done || o_word.valid |-> o_word.valid && o_done == (o_word.addr[2:0] == 3'h0); endproperty
  a_done: assert property (p_done) else $error("done");
  property p_bad; i_cmd_valid && o_cmd_ready && i_cmd.block > 3'h4 |=> o_cmd_ready ##[0:1] o_bad_block; endproperty
  a_bad: assert property (p_bad) else $error("bad");
endmodule
bind crba_core crba_checker chk (
  .i_clk       (i_clk),
  .i_nrst      (i_nrst),
  .i_cmd_valid (i_cmd_valid),
  .i_cmd       (i_cmd),
  .o_cmd_ready (o_cmd_ready),
  .o_word      (o_word),
  .o_done      (o_done),
  .o_bad_block (o_bad_block)
);

// ==== bench/tb_crba_core.sv ====
// testbench for the coefficient block addressing core
`timescale 1ns/10ps
module tb_crba_core;
  import crba_pkg::*;
  logic       i_clk, i_nrst, cv, rdy, dn, bad, v;
  crba_cmd_t  cmd;
  crba_word_t w;
  int         err_total, checks_done, n;
  crba_core uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_valid(cv), .i_cmd(cmd),
    .o_cmd_ready(rdy), .o_word(w), .o_done(dn), .o_bad_block(bad));
  crba_host host (.i_clk(i_clk), .i_ready(rdy), .o_valid(cv), .o_cmd(cmd));
  task chk(input logic [28:0] g, e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic walk(input logic [2:0] b, input logic wr, input logic [15:0] d, e);
    host.send(b, wr, d);
    for (int i = 7; i >= 0; i--) begin
      @(negedge i_clk);
      chk({dn, w}, {i == 0, 1'b1, wr, b, i[2:0], (b < 3'h3) ? {1'b0, b} + 4'h1 : {b, i[2]} - 4'h2, e});
    end
  endtask
  task t_fresh;
    for (int b = 0; b < 5; b++) walk(b[2:0], 1'b0, 16'hFFFF, 16'h0000);
    $display("fresh done");
  endtask
  task t_write;
    for (int b = 0; b < 5; b++) walk(b[2:0], 1'b1, 16'hA5C0 ^ b[15:0], 16'hA5C0 ^ b[15:0]);
    $display("write done");
  endtask
  task t_read;
    for (int b = 0; b < 5; b++) walk(b[2:0], 1'b0, 16'h0000, 16'hA5C0 ^ b[15:0]);
    $display("read done");
  endtask
  task t_bad;
    n = 0;
    v = 1'b0;
    host.send(3'h5, 1'b0, 16'h0000);
    repeat (10) begin
      n += bad;
      v |= w.valid;
      @(negedge i_clk);
    end
    chk(29'({n[1:0], v, rdy}), 29'h5);
    $display("bad done");
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    err_total = 0;
    checks_done = 0;
    i_nrst = 1'b0;
    repeat (2) @(negedge i_clk);
    i_nrst = 1'b1;
    t_fresh;
    t_write;
    t_bad;
    t_read;
    wrap_up;
  end
  initial begin
    #20000;
    err_total++;
    wrap_up;
  end
endmodule
